// ---- core/dnf_map.vh ----
`ifndef DNF_MAP_VH
`define DNF_MAP_VH
// How it works
// [RL1] Select bit 1 takes alternate channel samples
// [RL2] One converter can feed four down-converters
// [RL3] Frequency words 16 bits, step fs/65536
// [RL4] Oscillator one low byte, band one
// [RL5] Oscillator one high byte, band one
// [RL6] Oscillator two low byte, band one
// [RL7] Oscillator two high byte, band one
// [RL8] Oscillator three low byte, band one
// [RL9] Oscillator three high byte, band one
// [RL10] Oscillator four low byte, band two
// [RL11] Oscillator four applies only in dual band
// [RL12] Oscillator four high byte follows low
// [RL13] Enable bit: 0 single, 1 dual band
// [RL14] Software writes zero to upper select bits
// [RL15] All bytes and select clear on reset

// Register indices; byte address is four times the index
`define DNF_IDX_DUAL_BAND   4'h2
`define DNF_IDX_ALT_SEL     4'h6
`define DNF_IDX_O1_LOW      4'h7
`define DNF_IDX_O1_HIGH     4'h8
`define DNF_IDX_O2_LOW      4'h9
`define DNF_IDX_O2_HIGH     4'ha
`define DNF_IDX_O3_LOW      4'hb
`define DNF_IDX_O3_HIGH     4'hc
`define DNF_IDX_O4_LOW      4'hd
`define DNF_IDX_O4_HIGH     4'he
`define DNF_IDX_OSC_SEL     4'hf
// Field positions
`define DNF_SEL_BIT         0
`define DNF_DUAL_BIT        0
// Reset values
`define DNF_RST_BYTE        8'h00
// Register bus responses
`define DNF_RESP_OKAY       2'b00
`define DNF_RESP_SLVERR     2'b10
`endif

// ---- core/dnf_byte_reg.v ----
`timescale 1ns/1ns
`include "dnf_map.vh"
// One 8-bit read/write register byte
module dnf_byte_reg #(
  parameter [3:0] IDX = 4'h0
)(
  // Clock and reset
  input  wire       aclk,
  input  wire       aresetn,
  // Write port
  input  wire       wr_en,
  input  wire [3:0] wr_idx,
  input  wire [7:0] wr_data,
  // Stored value
  output reg  [7:0] q_ff
);
  // Clears on reset, loads on matching write
  always @(posedge aclk)
  begin
    if (!aresetn)
      q_ff <= `DNF_RST_BYTE; // [RL15]
    else if (wr_en && (wr_idx == IDX))
      q_ff <= wr_data;
  end
endmodule // dnf_byte_reg

// ---- core/dnf_phase_acc.v ----
`timescale 1ns/1ns
// Oscillator phase accumulator, one step of freq per sample
module dnf_phase_acc #(
  parameter W = 16
)(
  // Clock and reset
  input  wire         aclk,
  input  wire         aresetn,
  // Control
  input  wire         run,
  input  wire [W-1:0] freq,
  // Phase out
  output reg  [W-1:0] phase_ff
);
  wire [W-1:0] nxt_phase;
  // Wraps modulo 2^W, so one step is fs over 2^W
  assign nxt_phase = phase_ff + freq; // [RL3]
  always @(posedge aclk)
  begin
    if (!aresetn)
      phase_ff <= {W{1'b0}};
    else if (run)
      phase_ff <= nxt_phase;
    else
      phase_ff <= {W{1'b0}};
  end
endmodule // dnf_phase_acc

// ---- core/dnf_regs.v ----
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ns
`include "dnf_map.vh"
// Decimation page oscillator frequency registers with AXI4-Lite access
module dnf_regs #(
  parameter SW = 14
)(
  // Clock and reset
  input  wire          aclk,
  input  wire          aresetn,
  // AXI4-Lite write address
  input  wire          s_axi_awvalid,
  output wire          s_axi_awready,
  input  wire [7:0]    s_axi_awaddr,
  input  wire [2:0]    s_axi_awprot,
  // AXI4-Lite write data
  input  wire          s_axi_wvalid,
  output wire          s_axi_wready,
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  // AXI4-Lite write response
  output reg           s_axi_bvalid,
  input  wire          s_axi_bready,
  output reg  [1:0]    s_axi_bresp,
  // AXI4-Lite read address
  input  wire          s_axi_arvalid,
  output wire          s_axi_arready,
  input  wire [7:0]    s_axi_araddr,
  input  wire [2:0]    s_axi_arprot,
  // AXI4-Lite read data
  output reg           s_axi_rvalid,
  input  wire          s_axi_rready,
  output reg  [31:0]   s_axi_rdata,
  output reg  [1:0]    s_axi_rresp,
  // Converter samples, own and alternate channel
  input  wire [SW-1:0] own_sample,
  input  wire [SW-1:0] alt_sample,
  // Down-converter feed
  output reg  [SW-1:0] ddc_sample_ff,
  output reg           alt_in_use_ff,
  // Oscillator phases
  output wire [15:0]   band1_phase,
  output wire [15:0]   band2_phase,
  output reg  [1:0]    active_osc_ff,
  output reg           dual_band_ff
);
  // Write channel capture
  reg        aw_held_ff;
  reg [7:0]  aw_addr_ff;
  reg        w_held_ff;
  reg [31:0] w_data_ff;
  reg [3:0]  w_strb_ff;
  reg        alt_sel_ff;
  reg [1:0]  osc_pick_ff;
  wire       wr_fire;
  wire [3:0] wr_idx;
  wire       wr_en;
  wire       wr_known;
  wire [7:0] o1l;
  wire [7:0] o1h;
  wire [7:0] o2l;
  wire [7:0] o2h;
  wire [7:0] o3l;
  wire [7:0] o3h;
  wire [7:0] o4l;
  wire [7:0] o4h;
  reg  [15:0] band1_word;
  wire [15:0] band2_word;
  wire [3:0]  rd_idx;
  reg  [7:0]  rd_byte;
  reg         rd_known;

  // Address and data may arrive in either order
  assign s_axi_awready = !aw_held_ff && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_ff && !s_axi_bvalid;
  assign wr_fire       = aw_held_ff && w_held_ff && !s_axi_bvalid;
  assign wr_idx        = aw_addr_ff[5:2];
  // Only byte lane 0 carries data; misaligned or unmapped writes change nothing
  assign wr_en         = wr_fire && w_strb_ff[0] && wr_known;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_held_ff  <= 1'b0;
      w_data_ff  <= 32'h00000000;
      w_strb_ff  <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      else if (wr_fire)
        aw_held_ff <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      else if (wr_fire)
        w_held_ff <= 1'b0;
    end
  end

  // Decode of writable registers
  assign wr_known = (aw_addr_ff[7:6] == 2'b00) && (aw_addr_ff[1:0] == 2'b00) &&
                    ((wr_idx == `DNF_IDX_DUAL_BAND) || (wr_idx == `DNF_IDX_ALT_SEL) ||
                     (wr_idx == `DNF_IDX_OSC_SEL) ||
                     ((wr_idx >= `DNF_IDX_O1_LOW) && (wr_idx <= `DNF_IDX_O4_HIGH)));

  // Write response, unmapped address gets SLVERR
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `DNF_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_known ? `DNF_RESP_OKAY : `DNF_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Control registers, one bit each except the two-bit oscillator select; upper bits are dropped, software writes zero
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      alt_sel_ff   <= 1'b0; // [RL15]
      dual_band_ff <= 1'b0;
      osc_pick_ff  <= 2'b00;
    end
    else if (wr_en)
    begin
      if (wr_idx == `DNF_IDX_ALT_SEL)
        alt_sel_ff <= w_data_ff[`DNF_SEL_BIT]; // [RL14]
      if (wr_idx == `DNF_IDX_DUAL_BAND)
        dual_band_ff <= w_data_ff[`DNF_DUAL_BIT]; // [RL13]
      if (wr_idx == `DNF_IDX_OSC_SEL)
        osc_pick_ff <= w_data_ff[1:0];
    end
  end

  // Frequency word bytes, one instance per byte
  dnf_byte_reg #(.IDX(`DNF_IDX_O1_LOW)) u_o1l (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (wr_en),
    .wr_idx  (wr_idx),
    .wr_data (w_data_ff[7:0]),
    .q_ff    (o1l)
  ); // [RL4]
  dnf_byte_reg #(.IDX(`DNF_IDX_O1_HIGH)) u_o1h (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (wr_en),
    .wr_idx  (wr_idx),
    .wr_data (w_data_ff[7:0]),
    .q_ff    (o1h)
  ); // [RL5]
  dnf_byte_reg #(.IDX(`DNF_IDX_O2_LOW)) u_o2l (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (wr_en),
    .wr_idx  (wr_idx),
    .wr_data (w_data_ff[7:0]),
    .q_ff    (o2l)
  ); // [RL6]
  dnf_byte_reg #(.IDX(`DNF_IDX_O2_HIGH)) u_o2h (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (wr_en),
    .wr_idx  (wr_idx),
    .wr_data (w_data_ff[7:0]),
    .q_ff    (o2h)
  ); // [RL7]
  dnf_byte_reg #(.IDX(`DNF_IDX_O3_LOW)) u_o3l (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (wr_en),
    .wr_idx  (wr_idx),
    .wr_data (w_data_ff[7:0]),
    .q_ff    (o3l)
  ); // [RL8]
  dnf_byte_reg #(.IDX(`DNF_IDX_O3_HIGH)) u_o3h (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (wr_en),
    .wr_idx  (wr_idx),
    .wr_data (w_data_ff[7:0]),
    .q_ff    (o3h)
  ); // [RL9]
  dnf_byte_reg #(.IDX(`DNF_IDX_O4_LOW)) u_o4l (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (wr_en),
    .wr_idx  (wr_idx),
    .wr_data (w_data_ff[7:0]),
    .q_ff    (o4l)
  ); // [RL10]
  dnf_byte_reg #(.IDX(`DNF_IDX_O4_HIGH)) u_o4h (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (wr_en),
    .wr_idx  (wr_idx),
    .wr_data (w_data_ff[7:0]),
    .q_ff    (o4h)
  ); // [RL12]

  // Band one word picked by oscillator select; code 3 falls back to one
  always @*
  begin
    case (osc_pick_ff)
      2'b01:   band1_word = {o2h, o2l};
      2'b10:   band1_word = {o3h, o3l};
      default: band1_word = {o1h, o1l};
    endcase
  end
  // Band two word is forced to zero outside dual band
  assign band2_word = dual_band_ff ? {o4h, o4l} : 16'h0000; // [RL11]

  // Phase accumulators; band two holds at zero in single band
  dnf_phase_acc #(.W(16)) u_acc1 (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .run      (1'b1),
    .freq     (band1_word),
    .phase_ff (band1_phase)
  ); // [RL3]
  dnf_phase_acc #(.W(16)) u_acc2 (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .run      (dual_band_ff),
    .freq     (band2_word),
    .phase_ff (band2_phase)
  ); // [RL11]

  // Input steering; the idle channel may then be powered down
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ddc_sample_ff <= {SW{1'b0}};
      alt_in_use_ff <= 1'b0;
      active_osc_ff <= 2'b00;
    end
    else
    begin
      ddc_sample_ff <= alt_sel_ff ? alt_sample : own_sample; // [RL1]
      alt_in_use_ff <= alt_sel_ff; // [RL2]
      active_osc_ff <= (osc_pick_ff == 2'b11) ? 2'b00 : osc_pick_ff;
    end
  end

  // Read channel
  assign rd_idx        = s_axi_araddr[5:2];
  assign s_axi_arready = !s_axi_rvalid;

  always @*
  begin
    rd_known = (s_axi_araddr[7:6] == 2'b00) && (s_axi_araddr[1:0] == 2'b00);
    case (rd_idx)
      `DNF_IDX_DUAL_BAND: rd_byte = {7'h00, dual_band_ff};
      `DNF_IDX_ALT_SEL:   rd_byte = {7'h00, alt_sel_ff};
      `DNF_IDX_O1_LOW:    rd_byte = o1l;
      `DNF_IDX_O1_HIGH:   rd_byte = o1h;
      `DNF_IDX_O2_LOW:    rd_byte = o2l;
      `DNF_IDX_O2_HIGH:   rd_byte = o2h;
      `DNF_IDX_O3_LOW:    rd_byte = o3l;
      `DNF_IDX_O3_HIGH:   rd_byte = o3h;
      `DNF_IDX_O4_LOW:    rd_byte = o4l;
      `DNF_IDX_O4_HIGH:   rd_byte = o4h;
      `DNF_IDX_OSC_SEL:   rd_byte = {6'h00, osc_pick_ff};
      default:
      begin
        rd_byte  = 8'h00;
        rd_known = 1'b0;
      end
    endcase
  end

  // Read data registered; one read outstanding
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `DNF_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_known ? {24'h000000, rd_byte} : 32'h00000000; // Refused reads show 0
      s_axi_rresp  <= rd_known ? `DNF_RESP_OKAY : `DNF_RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule // dnf_regs

// ---- tb/dnf_regs_assertions.sv ----
`timescale 1ns/1ns
// Watches the bus handshakes and the datapath outputs
module dnf_chk #(
  parameter SW = 14
)(
  // Clock and reset
  input wire          aclk,
  input wire          aresetn,
  // Bus handshakes
  input wire          s_axi_awready,
  input wire          s_axi_wready,
  input wire          s_axi_bvalid,
  input wire          s_axi_bready,
  input wire [1:0]    s_axi_bresp,
  input wire          s_axi_arvalid,
  input wire          s_axi_arready,
  input wire          s_axi_rvalid,
  input wire          s_axi_rready,
  input wire [31:0]   s_axi_rdata,
  // Datapath
  input wire [SW-1:0] own_sample,
  input wire [SW-1:0] alt_sample,
  input wire [SW-1:0] ddc_sample_ff,
  input wire          alt_in_use_ff,
  input wire [15:0]   band2_phase,
  input wire          dual_band_ff
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Only judged while the select has been steady, so mirror lag cannot matter
  chk_mux_feed: assert property (
    $past(aresetn) && alt_in_use_ff == $past(alt_in_use_ff) |->
      ddc_sample_ff == (alt_in_use_ff ? $past(alt_sample) : $past(own_sample)))
    else $error("Feed took the wrong channel");
  chk_band2_idle: assert property (
    !dual_band_ff && !$past(dual_band_ff) |-> band2_phase == 16'h0000)
    else $error("Band two phase moved in single band");
  chk_rdata_byte: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("Read data beyond one byte");
  chk_b_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response dropped early");
  chk_r_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("Read data dropped early");
  chk_w_refused: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("Write taken while response pending");
  chk_ar_refused: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("Read taken while data pending");
  chk_rd_answer: assert property (
    s_axi_arvalid && s_axi_arready |-> ##1 s_axi_rvalid)
    else $error("Read answer late");
  chk_b_release: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("Write response not released");

  // Main scenarios
  cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
  cover property (alt_in_use_ff);
  cover property (dual_band_ff && band2_phase != 16'h0000);
endmodule // dnf_chk

bind dnf_regs dnf_chk #(.SW(SW)) dnf_chk_inst (.*);

// ---- tb/test_ddc_nco_frequency_regs.sv ----
`timescale 1ns/1ns
// Register bench: bus tasks plus datapath probes
module test_ddc_nco_frequency_regs;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, alt_in_use_ff, dual_band_ff;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, active_osc_ff;
  logic [13:0] own_sample, alt_sample, ddc_sample_ff;
  logic [15:0] band1_phase, band2_phase;
  logic [15:0] words [0:3];
  int          failures, cmp_count;

  dnf_regs #(.SW(14)) dnf_regs_inst (.*);

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Streams step every cycle so a stale feed shows
  always @(posedge aclk)
  begin
    own_sample <= own_sample + 14'h0003;
    alt_sample <= alt_sample + 14'h0005;
  end

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Address and data offered together, each dropped once taken
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, ga, gw;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    {ta, tw} = 2'b00;
    while (!(ta && tw))
    begin
      @(negedge aclk);
      {ga, gw} = {!ta && s_axi_awready, !tw && s_axi_wready};
      @(posedge aclk);
      if (ga) {s_axi_awvalid, ta} <= 2'b01;
      if (gw) {s_axi_wvalid, tw} <= 2'b01;
      #0;
    end
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er);
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    chk("rdata", s_axi_rdata, ex);
    chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask

  // Feed must be last cycle's sample of the chosen channel
  task feed(input logic alt);
    logic [13:0] e;
    @(negedge aclk);
    e = alt ? alt_sample - 14'h0005 : own_sample - 14'h0003;
    chk("feed", {18'h0, ddc_sample_ff}, {18'h0, e});
    chk("alt in use", {31'h0, alt_in_use_ff}, {31'h0, alt});
  endtask

  // Phase advance over one cycle equals the word in use
  task step(input logic [15:0] w, input logic b2);
    logic [15:0] p0;
    @(negedge aclk);
    p0 = b2 ? band2_phase : band1_phase;
    @(negedge aclk);
    p0 = (b2 ? band2_phase : band1_phase) - p0;
    chk("phase step", {16'h0, p0}, {16'h0, w});
  endtask

  task zeros;
    for (int i = 6; i < 15; i++) rd(8'(i * 4), 32'h0, 2'b00);
  endtask

  task conclude;
    if (failures == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {s_axi_awprot, s_axi_arprot, s_axi_wstrb} = 10'h001;
    {own_sample, alt_sample} = 28'h0;
    words = '{16'h1234, 16'h0f0e, 16'h8001, 16'h4321};
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    zeros;
    // Upper data bits are noise the byte registers must drop
    for (int i = 0; i < 4; i++)
    begin
      wr(8'(8'h1c + 8 * i), {24'habcdee, words[i][7:0]}, 2'b00);
      wr(8'(8'h20 + 8 * i), {24'h5a5a5a, words[i][15:8]}, 2'b00);
    end
    for (int i = 0; i < 4; i++)
    begin
      rd(8'(8'h1c + 8 * i), {24'h0, words[i][7:0]}, 2'b00);
      rd(8'(8'h20 + 8 * i), {24'h0, words[i][15:8]}, 2'b00);
    end
    // Each oscillator choice; code three falls back to the first
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h3c, 32'(i), 2'b00);
      step(words[(i == 3) ? 0 : i], 1'b0);
      chk("active osc", {30'h0, active_osc_ff}, (i == 3) ? 32'h0 : 32'(i));
    end
    step(16'h0000, 1'b1);
    wr(8'h08, 32'h1, 2'b00);
    chk("dual band", {31'h0, dual_band_ff}, 32'h1);
    step(words[3], 1'b1);
    wr(8'h08, 32'h0, 2'b00);
    repeat (2) @(posedge aclk);
    step(16'h0000, 1'b1);
    feed(1'b0);
    wr(8'h18, 32'h1, 2'b00);
    rd(8'h18, 32'h1, 2'b00);
    feed(1'b1);
    wr(8'h18, 32'h0, 2'b00);
    feed(1'b0);
    // Unmapped and misaligned places refuse and change nothing
    wr(8'h40, 32'h5a, 2'b10);
    wr(8'h1d, 32'h77, 2'b10);
    rd(8'h04, 32'h0, 2'b10);
    rd(8'h1d, 32'h0, 2'b10);
    rd(8'h1c, {24'h0, words[0][7:0]}, 2'b00);
    // Second reset in mid-run
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    zeros;
    conclude;
  end

  // Hang guard, far beyond the few hundred cycles of the tests
  initial
  begin
    repeat (20000) @(posedge aclk);
    failures++;
    conclude;
  end
endmodule // test_ddc_nco_frequency_regs
